// >>> src/port_fail_and_error_capture.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - stop-on-fail clear: keep sending packets even after output failed.
// - stop-on-fail set and output failed: raise port error, stop sending.
// - stopped by stop-on-fail with drop enabled: discard pending packets.
// - drop clear: keep retrying packets rejected for transmission errors.
// - switch, drop set, over threshold: drop rejected packets; resume below.
// - lockout: no packets either way; training and link-requests continue.
// - lockout: every incoming packet gets packet-not-accepted.
// - port control bit 0 is read-only and reads 1 (serial port).
// - port control bits 18..4 are read-only zero.
// - header upper half reads next-block pointer zero.
// - header lower half reads feature identifier seven.
// - capture bit 31 set on load/store engine error reply.
// - capture bit 30 set on message transmit unit error reply.
// - capture bit 28 set on bad message payload size or segment.
// - capture bit 27 set on illegal fields in response packets.
// - capture bit 27 set on illegal fields in request packets.
// - writing zero to a set capture bit clears it.
// - capture bits 29 and 26 read as zero.
// - capture bit 25 set on message request timeout.
// - capture bit 24 set on response timeout.
module port_fail_and_error_capture
#(
   parameter bit IS_SWITCH = 1'b1
)
(
   input  wire logic                              clock,
   input  wire logic                              rst_n,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [port_fail_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                       pwdata,
   output logic      [31:0]                       prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire port_fail_pkg::errEvents_s         events,
   input  wire port_fail_pkg::linkState_s         link,
   output port_fail_pkg::portStatus_s             status
);
   import port_fail_pkg::*;

   // ==========================================================
   // apb slave
   logic        stopOnFail_ff;
   logic        dropEnable_ff;
   logic        lockout_ff;
   logic [7:0]  capture_ff;
   logic [7:0]  nxt_capture;
   logic [7:0]  capSet;
   logic [7:0]  capClear;
   logic        setupPhase;
   logic        accessDone;
   logic        wrCtrl;
   logic        wrCap;
   logic        hitCtrl;
   logic        hitHdr;
   logic        hitCap;
   logic [31:0] ctrlWord;
   logic [31:0] hdrWord;
   logic [31:0] capWord;
   logic [31:0] nxt_prdata;
   portStatus_s nxt_status;

   // pready rises in the first access cycle: zero wait states
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable && pready;
   assign hitCtrl    = (paddr == ADDR_PORT_CTRL);
   assign hitHdr     = (paddr == ADDR_ERR_HDR);
   assign hitCap     = (paddr == ADDR_ERR_CAP);
   assign wrCtrl     = accessDone && pwrite && hitCtrl;
   assign wrCap      = accessDone && pwrite && hitCap;

   always_comb
   begin
      ctrlWord           = 32'h0000_0000;
      ctrlWord[BIT_STOP] = stopOnFail_ff;
      ctrlWord[BIT_DROP] = dropEnable_ff;
      ctrlWord[BIT_LOCK] = lockout_ff;
      ctrlWord[BIT_TYPE] = PORT_TYPE_SER;
   end

   assign hdrWord = {NEXT_BLOCK_PTR, FEATURE_ID};
   assign capWord = {capture_ff & CAP_MASK, 24'h00_0000};

   always_comb
   begin
      nxt_prdata = 32'h0000_0000;
      if (hitCtrl)
      begin
         nxt_prdata = ctrlWord;
      end
      else if (hitHdr)
      begin
         nxt_prdata = hdrWord;
      end
      else if (hitCap)
      begin
         nxt_prdata = capWord;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setupPhase;
         pslverr <= setupPhase && !(hitCtrl || hitHdr || hitCap);
         prdata  <= (setupPhase && !pwrite) ? nxt_prdata : 32'h0000_0000;
      end
   end

   // ==========================================================
   // port control tail
   // unmapped or header writes are refused with pslverr or ignored
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stopOnFail_ff <= RST_STOP;
         dropEnable_ff <= RST_DROP;
         lockout_ff    <= RST_LOCK;
      end
      else if (wrCtrl)
      begin
         stopOnFail_ff <= pwdata[BIT_STOP];
         dropEnable_ff <= pwdata[BIT_DROP];
         lockout_ff    <= pwdata[BIT_LOCK];
      end
   end

   // ==========================================================
   // port behaviour, registered so each output is a flop
   always_comb
   begin
      nxt_status.portError       = stopOnFail_ff && link.outputFailed;
      nxt_status.txEnable        = !lockout_ff &&
                                   !(stopOnFail_ff && link.outputFailed);
      nxt_status.discardPending  = stopOnFail_ff && link.outputFailed &&
                                   dropEnable_ff;
      // only a switch may drop; an endpoint always retries
      nxt_status.dropRejected    = IS_SWITCH && dropEnable_ff &&
                                   link.overThreshold;
      nxt_status.retryRejected   = !nxt_status.dropRejected;
      nxt_status.rxAccept        = !lockout_ff;
      nxt_status.rxRejectAll     = lockout_ff;
      // training and link-request handling never blocked by lockout
      nxt_status.linkMaintEnable = 1'b1;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status <= STATUS_RESET;
      end
      else
      begin
         status <= nxt_status;
      end
   end

   // ==========================================================
   // error capture
   always_comb
   begin
      capSet            = 8'h00;
      capSet[CAP_IO]    = events.ioErrorReply;
      capSet[CAP_MSG]   = events.msgErrorReply;
      capSet[CAP_FMT]   = events.badMessagePayload;
      capSet[CAP_ILL]   = events.illegalRespField ||
                          events.illegalReqField;
      capSet[CAP_MRL]   = events.messageRequestLate;
      capSet[CAP_RSL]   = events.responseLate;
   end

   // a zero written clears, a one is ignored; a new event beats the clear
   assign capClear    = wrCap ? ~pwdata[CAP_LSB +: 8] : 8'h00;
   assign nxt_capture = ((capture_ff & ~capClear) | capSet) & CAP_MASK;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         capture_ff <= CAP_RESET;
      end
      else
      begin
         capture_ff <= nxt_capture;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   logic rdCtrlDone;
   logic rdHdrDone;
   logic rdCapDone;
   assign rdCtrlDone = accessDone && !pwrite && hitCtrl;
   assign rdHdrDone  = accessDone && !pwrite && hitHdr;
   assign rdCapDone  = accessDone && !pwrite && hitCap;

   a_keep_sending: assert property (
      (!stopOnFail_ff && !lockout_ff) |=> status.txEnable)
      else $error("port stopped although stop-on-fail is clear");

   a_stop_on_fail: assert property (
      (stopOnFail_ff && link.outputFailed) |=> (!status.txEnable && status.portError))
      else $error("stop-on-fail did not stop the port");

   a_discard_pending: assert property (
      status.discardPending |-> $past(stopOnFail_ff && link.outputFailed && dropEnable_ff))
      else $error("discard without stop and drop enable");

   a_retry_rejected: assert property (
      !dropEnable_ff |=> (status.retryRejected && !status.dropRejected))
      else $error("rejected packet not retried with drop clear");

   a_drop_switch: assert property (
      (dropEnable_ff && IS_SWITCH) |=> (status.dropRejected == $past(link.overThreshold)))
      else $error("drop does not follow the failed threshold");

   a_lockout_block: assert property (
      lockout_ff |=> (!status.txEnable && !status.rxAccept && status.linkMaintEnable))
      else $error("lockout let packets through or stopped link maintenance");

   a_lockout_nak: assert property (
      $rose(lockout_ff) |=> status.rxRejectAll [*2])
      else $error("locked port did not reject incoming packets");

   a_ctrl_fixed: assert property (
      rdCtrlDone |-> (prdata[BIT_TYPE] && prdata[RSV_HI:RSV_LO] == 15'h0000))
      else $error("port control fixed bits read wrong");

   a_header_value: assert property (
      rdHdrDone |-> (prdata == 32'h0000_0007))
      else $error("error block header read wrong");

   a_io_capture: assert property (
      events.ioErrorReply |=> capture_ff[CAP_IO])
      else $error("error reply not captured");

   a_msg_capture: assert property (
      events.msgErrorReply |=> capture_ff[CAP_MSG])
      else $error("message error reply not captured");

   a_fmt_capture: assert property (
      events.badMessagePayload |=> capture_ff[CAP_FMT])
      else $error("bad payload not captured");

   a_ill_capture: assert property (
      (events.illegalRespField || events.illegalReqField) |=> capture_ff[CAP_ILL])
      else $error("illegal field not captured");

   a_late_capture: assert property (
      events.messageRequestLate |=> capture_ff[CAP_MRL])
      else $error("message request timeout not captured");

   a_resp_late: assert property (
      events.responseLate |=> capture_ff[CAP_RSL])
      else $error("response timeout not captured");

   a_zero_clears: assert property (
      (wrCap && !pwdata[CAP_LSB + CAP_IO] && !events.ioErrorReply) |=> !capture_ff[CAP_IO])
      else $error("write of zero did not clear the flag");

   a_flag_sticky: assert property (
      (capture_ff[CAP_MSG] && !(wrCap && !pwdata[CAP_LSB + CAP_MSG])) |=>
      capture_ff[CAP_MSG])
      else $error("flag lost without a clearing write");

   a_reserved_zero: assert property (
      (!capture_ff[CAP_RSV29] && !capture_ff[CAP_RSV26]))
      else $error("reserved capture bit set");

   a_ill_request: assert property (
      events.illegalReqField |=> capture_ff[CAP_ILL])
      else $error("illegal request field not captured");

   a_io_sticky: assert property (
      (capture_ff[CAP_IO] && !(wrCap && !pwdata[CAP_LSB + CAP_IO])) |=>
      capture_ff[CAP_IO])
      else $error("error reply flag lost without a clearing write");

   a_fmt_sticky: assert property (
      (capture_ff[CAP_FMT] && !(wrCap && !pwdata[CAP_LSB + CAP_FMT])) |=>
      capture_ff[CAP_FMT])
      else $error("payload flag lost without a clearing write");

   a_late_sticky: assert property (
      (capture_ff[CAP_RSL] && !(wrCap && !pwdata[CAP_LSB + CAP_RSL])) |=>
      capture_ff[CAP_RSL])
      else $error("timeout flag lost without a clearing write");

   // an event landing on the clearing edge must not be lost
   a_set_wins: assert property (
      (wrCap && !pwdata[CAP_LSB + CAP_IO] && events.ioErrorReply) |=>
      capture_ff[CAP_IO])
      else $error("clearing write swallowed a new event");

   a_no_spurious: assert property (
      (!capture_ff[CAP_IO] && !events.ioErrorReply) |=> !capture_ff[CAP_IO])
      else $error("error reply flag set without an event");

   // read data is registered at the setup edge, so compare one cycle back
   a_cap_readback: assert property (
      rdCapDone |-> (prdata == {$past(capture_ff), 24'h00_0000}))
      else $error("capture word read wrong");

   a_ctrl_readback: assert property (
      rdCtrlDone |->
      (prdata[BIT_STOP:BIT_LOCK] == $past({stopOnFail_ff, dropEnable_ff, lockout_ff})))
      else $error("port control bits read wrong");

   a_ctrl_write: assert property (
      wrCtrl |=> ({stopOnFail_ff, dropEnable_ff, lockout_ff} ==
                  $past({pwdata[BIT_STOP], pwdata[BIT_DROP], pwdata[BIT_LOCK]})))
      else $error("port control write did not land");

   a_hdr_no_error: assert property (
      (accessDone && hitHdr) |-> !pslverr)
      else $error("header access flagged as error");

   a_drop_needs: assert property (
      status.dropRejected |-> $past(dropEnable_ff && link.overThreshold))
      else $error("packets dropped without drop enable and threshold");

   a_drop_heals: assert property (
      !link.overThreshold |=> !status.dropRejected)
      else $error("dropping went on below the failed threshold");

   a_tx_after_fail: assert property (
      (!stopOnFail_ff && !lockout_ff && link.outputFailed) |=>
      (status.txEnable && !status.portError))
      else $error("port stopped on failure with stop-on-fail clear");

   a_error_cause: assert property (
      status.portError |-> $past(stopOnFail_ff && link.outputFailed))
      else $error("port error raised without stop-on-fail and failure");

   a_no_discard: assert property (
      !dropEnable_ff |=> !status.discardPending)
      else $error("pending packets discarded with drop clear");

   a_discard_when: assert property (
      (stopOnFail_ff && link.outputFailed && dropEnable_ff) |=> status.discardPending)
      else $error("stopped port with drop enable kept pending packets");

   a_lockout_reject: assert property (
      lockout_ff |=> status.rxRejectAll)
      else $error("locked port accepted an incoming packet");

   a_lockout_release: assert property (
      !lockout_ff |=> (status.rxAccept && !status.rxRejectAll))
      else $error("unlocked port rejected incoming packets");

   c_stop_drop: cover property (stopOnFail_ff && dropEnable_ff && link.outputFailed);
   c_lockout_on: cover property ($rose(lockout_ff));
   c_set_clear_race: cover property (wrCap && !pwdata[CAP_LSB + CAP_IO] && events.ioErrorReply);
   c_bad_address: cover property (accessDone && pslverr);
   c_lock_on_fail: cover property (lockout_ff && stopOnFail_ff && link.outputFailed);
endmodule

`default_nettype wire

// >>> src/port_fail_pkg.sv
`default_nettype none
package port_fail_pkg;
   // ==========================================================
   // register map
   localparam int                ADDR_W          = 16;
   localparam logic [ADDR_W-1:0] ADDR_PORT_CTRL  = 16'h1000;
   localparam logic [ADDR_W-1:0] ADDR_ERR_HDR    = 16'h2000;
   localparam logic [ADDR_W-1:0] ADDR_ERR_CAP    = 16'h2008;

   // ==========================================================
   // port control tail fields
   localparam int                BIT_STOP        = 3;
   localparam int                BIT_DROP        = 2;
   localparam int                BIT_LOCK        = 1;
   localparam int                BIT_TYPE        = 0;
   localparam int                RSV_HI          = 18;
   localparam int                RSV_LO          = 4;
   localparam logic              RST_STOP        = 1'b0;
   localparam logic              RST_DROP        = 1'b0;
   localparam logic              RST_LOCK        = 1'b0;
   localparam logic              PORT_TYPE_SER   = 1'b1;

   // ==========================================================
   // error block header
   localparam logic [15:0]       NEXT_BLOCK_PTR  = 16'h0000;
   localparam logic [15:0]       FEATURE_ID      = 16'h0007;

   // ==========================================================
   // error capture, kept as its top byte (bits 31..24)
   localparam int                CAP_LSB         = 24;
   localparam int                CAP_IO          = 7;
   localparam int                CAP_MSG         = 6;
   localparam int                CAP_RSV29       = 5;
   localparam int                CAP_FMT         = 4;
   localparam int                CAP_ILL         = 3;
   localparam int                CAP_RSV26       = 2;
   localparam int                CAP_MRL         = 1;
   localparam int                CAP_RSL         = 0;
   localparam logic [7:0]        CAP_MASK        = 8'hdb;
   localparam logic [7:0]        CAP_RESET       = 8'h00;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic ioErrorReply;
      logic msgErrorReply;
      logic badMessagePayload;
      logic illegalRespField;
      logic illegalReqField;
      logic messageRequestLate;
      logic responseLate;
   } errEvents_s;

   typedef struct packed {
      logic outputFailed;
      logic overThreshold;
   } linkState_s;

   typedef struct packed {
      logic txEnable;
      logic portError;
      logic discardPending;
      logic dropRejected;
      logic retryRejected;
      logic rxAccept;
      logic rxRejectAll;
      logic linkMaintEnable;
   } portStatus_s;

   localparam portStatus_s STATUS_RESET = '{
      txEnable: 1'b1, portError: 1'b0, discardPending: 1'b0,
      dropRejected: 1'b0, retryRejected: 1'b1, rxAccept: 1'b1,
      rxRejectAll: 1'b0, linkMaintEnable: 1'b1};
endpackage
`default_nettype wire

// >>> verification/link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// far side: transfer units and link monitor
module link_partner_model
   import port_fail_pkg::*;
(
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire port_fail_pkg::errEvents_s evReq,
   input  wire port_fail_pkg::linkState_s lnkReq,
   output port_fail_pkg::errEvents_s      events,
   output port_fail_pkg::linkState_s      link
);
   // registered so every pulse lands one clean cycle later, as wide as it was driven
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         events <= '0;
         link   <= '0;
      end
      else
      begin
         events <= evReq;
         link   <= lnkReq;
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_port_fail_and_error_capture.sv
`timescale 1ns/100ps
`default_nettype none
module tb_port_fail_and_error_capture;
   import port_fail_pkg::*;
   // ==========================================
   // signals
   logic              clock   = 1'b0;
   logic              rst_n   = 1'b0;
   logic              psel    = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite  = 1'b0;
   logic [ADDR_W-1:0] paddr   = '0;
   logic [31:0]       pwdata  = '0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   errEvents_s        evReq   = '0;
   linkState_s        lnkReq  = '0;
   errEvents_s        events;
   linkState_s        link;
   portStatus_s       status;
   logic [32:0]       expQ[$];
   logic [32:0]       cur;
   logic [31:0]       rng     = 32'h4246;
   logic [31:0]       acc     = '0;
   logic [31:0]       d;
   int                capBit[7] = '{31, 30, 28, 27, 27, 25, 24};
   int                nErrors = 0;
   int                samplesChecked = 0;
   int                cycles  = 0;

   always #12.5 clock = ~clock;

   port_fail_and_error_capture u_port_fail_and_error_capture
   (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .events(events), .link(link), .status(status)
   );

   link_partner_model u_link_partner_model
   (
      .clock(clock), .rst_n(rst_n), .evReq(evReq), .lnkReq(lnkReq),
      .events(events), .link(link)
   );

   // ==========================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tallyAndFinish();
      $display("mismatches %0d, comparisons %0d", nErrors, samplesChecked);
      if (nErrors == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   function automatic portStatus_s expStatus(input logic [3:0] c, input linkState_s l);
      portStatus_s s;
      s.portError       = c[3] && l.outputFailed;
      s.txEnable        = !c[1] && !s.portError;
      s.discardPending  = s.portError && c[2];
      s.dropRejected    = c[2] && l.overThreshold;
      s.retryRejected   = !s.dropRejected;
      s.rxAccept        = !c[1];
      s.rxRejectAll     = c[1];
      s.linkMaintEnable = 1'b1;
      return s;
   endfunction

   // one idle edge after release, so psel is never assigned twice in a step
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                      input logic [31:0] exp, input logic err);
      expQ.push_back({err, exp});
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   // ==========================================
   // watcher and timeout
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         nErrors++;
         tallyAndFinish();
      end
      else if (psel && penable && pready === 1'b1)
      begin
         cur = expQ.pop_front();
         check({31'h0, pslverr}, {31'h0, cur[32]});
         if (!pwrite)
            check(prdata, cur[31:0]);
      end
   end

   // ==========================================
   // scenarios
   initial
   begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      apb(0, ADDR_ERR_HDR, 0, 32'h00000007, 0);
      apb(1, ADDR_ERR_HDR, 32'hffffffff, 0, 0);
      apb(0, ADDR_ERR_HDR, 0, 32'h00000007, 0);
      apb(0, ADDR_PORT_CTRL, 0, 32'h00000001, 0);
      apb(0, ADDR_ERR_CAP, 0, 32'h0, 0);
      apb(0, 16'h1004, 0, 32'h0, 1);
      apb(1, 16'h1004, 32'hffffffff, 0, 1);
      for (int i = 0; i < 7; i++)
      begin
         evReq <= errEvents_s'(7'h40 >> i);
         @(posedge clock);
         evReq <= '0;
         repeat (2) @(posedge clock);
         acc = acc | (32'h1 << capBit[i]);
         apb(0, ADDR_ERR_CAP, 0, acc, 0);
      end
      apb(1, ADDR_ERR_CAP, 32'hffffffff, 0, 0);
      apb(0, ADDR_ERR_CAP, 0, 32'hdb000000, 0);
      for (int i = 0; i < 7; i++)
      begin
         acc = acc & ~(32'h1 << capBit[i]);
         apb(1, ADDR_ERR_CAP, ~(32'h1 << capBit[i]), 0, 0);
         apb(0, ADDR_ERR_CAP, 0, acc, 0);
      end
      // event and clearing write meet on one edge: the event must win
      fork
         apb(1, ADDR_ERR_CAP, 32'h7fffffff, 0, 0);
         begin
            evReq <= errEvents_s'(7'h40);
            @(posedge clock);
            evReq <= '0;
         end
      join
      apb(0, ADDR_ERR_CAP, 0, 32'h80000000, 0);
      apb(1, ADDR_ERR_CAP, 32'h7fffffff, 0, 0);
      apb(0, ADDR_ERR_CAP, 0, 32'h0, 0);
      // random control words against random link levels
      for (int i = 0; i < 48; i++)
      begin
         d = xs();
         lnkReq <= linkState_s'(d[5:4]);
         apb(1, ADDR_PORT_CTRL, d, 0, 0);
         apb(0, ADDR_PORT_CTRL, 0, (d & 32'he) | 32'h1, 0);
         check({24'h0, status}, {24'h0, expStatus(d[3:0], lnkReq)});
      end
      // mid-run reset drops control bits and flags
      evReq <= errEvents_s'(7'h01);
      @(posedge clock);
      evReq <= '0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      check({24'h0, status}, {24'h0, STATUS_RESET});
      rst_n <= 1'b1;
      @(posedge clock);
      apb(0, ADDR_PORT_CTRL, 0, 32'h00000001, 0);
      apb(0, ADDR_ERR_CAP, 0, 32'h0, 0);
      tallyAndFinish();
   end
endmodule
`default_nettype wire
